// ### rtl/csx_addr.sv
`timescale 1ns/1ps
`default_nettype none
// file operand address formation
module csx_addr
(
	// operand fields
	input wire logic [7:0] file_addr,
	input wire logic access_bit,
	input wire logic ext_en,
	// pointer and bank
	input wire logic [3:0] bank_sel,
	input wire logic [11:0] ptr_two,
	// result
	output logic [11:0] eff_addr,
	output logic indexed
);
	// ==========================================
	// address mux
	always_comb
	begin
		indexed = 1'b0;
		if (access_bit) // [RULE_12]
		begin
			eff_addr = {bank_sel, file_addr};
		end
		else if (ext_en && file_addr <= csx_pkg::CSX_IDX_LIMIT) // [RULE_13]
		begin
			eff_addr = ptr_two + {4'h0, file_addr};
			indexed = 1'b1;
		end
		else
		begin
			// addresses below 0x60 to bank zero, 0x60 and up to special area
			eff_addr = (file_addr < csx_pkg::CSX_ACCESS_SPLIT) ? {4'h0, file_addr}
				: {csx_pkg::CSX_ACCESS_HI, file_addr};
		end
	end
endmodule // csx_addr
`default_nettype wire

// ### rtl/csx_cmp.sv
`timescale 1ns/1ps
`default_nettype none
// unsigned subtract compare, no flags
module csx_cmp
(
	// operands
	input wire logic [7:0] file_val,
	input wire logic [7:0] work_val,
	// result
	output logic equal
);
	logic [7:0] diff; // difference, flags never leave here
	always_comb
	begin
		diff = file_val - work_val; // [RULE_01]
		equal = (diff == 8'h00);
	end
endmodule // csx_cmp
`default_nettype wire

// ### rtl/csx_decoder.sv
`timescale 1ns/1ps
`default_nettype none
// decoder for compare-skip and the extended pointer group
module csx_decoder
(
	// clock and reset
	input wire logic clock,
	input wire logic rst_n,
	// configuration
	input wire logic ext_set_enable,
	// fetch side
	input wire logic instr_valid,
	input wire logic [15:0] instr_word,
	input wire logic instr_two_word,
	// datapath state
	input wire logic [7:0] file_data,
	input wire logic [7:0] working_register,
	input wire logic [3:0] bank_select_register,
	input wire logic [11:0] pointer_two,
	// decoded outputs
	output logic [3:0] op_code,
	output logic op_valid,
	output logic [1:0] ptr_sel,
	output logic [7:0] literal,
	output logic [11:0] addr_a,
	output logic [11:0] addr_b,
	output logic addr_indexed,
	output logic do_return,
	output logic do_call,
	output logic skip_flush,
	output logic busy
);
	// ==========================================
	// state
	typedef enum logic [1:0] {CSX_RUN, CSX_SKIP1, CSX_SKIP2, CSX_SECOND} csx_state_type;
	csx_state_type state_r, state_nxt;
	logic [3:0] op_r, op_nxt;
	logic valid_r, valid_nxt;
	logic [1:0] ptr_r, ptr_nxt;
	logic [7:0] lit_r, lit_nxt;
	logic [11:0] a_r, a_nxt, b_r, b_nxt;
	logic idx_r, idx_nxt, ret_r, ret_nxt, call_r, call_nxt, fl_r, fl_nxt;
	logic pend_ret_r, pend_ret_nxt; // return pending after pointer update
	logic pend_two_r, pend_two_nxt; // second cycle of a two-cycle op due next
	logic pend_mss_r, pend_mss_nxt; // second word is an indexed destination
	logic ext_en_r, ext_en_nxt; // configuration registered every cycle
	logic [11:0] eff; // formed file operand address
	logic eff_idx;
	logic equal; // compare outcome

	// ==========================================
	// helpers
	csx_addr u_addr (
		.file_addr(instr_word[7:0]),
		.access_bit(instr_word[8]),
		.ext_en(ext_en_r),
		.bank_sel(bank_select_register),
		.ptr_two(pointer_two),
		.eff_addr(eff),
		.indexed(eff_idx)
	);
	csx_cmp u_cmp (
		.file_val(file_data),
		.work_val(working_register),
		.equal(equal)
	);

	// indexed source/dest through pointer two
	function automatic logic [11:0] csx_idx(input logic [11:0] p, input logic [6:0] z);
		csx_idx = p + {5'h00, z};
	endfunction

	// ==========================================
	// next-state decode
	always_comb
	begin
		state_nxt = state_r;
		op_nxt = csx_pkg::CSX_NONE;
		valid_nxt = 1'b0;
		ptr_nxt = ptr_r;
		lit_nxt = lit_r;
		a_nxt = a_r;
		b_nxt = b_r;
		idx_nxt = 1'b0;
		ret_nxt = 1'b0;
		call_nxt = 1'b0;
		fl_nxt = 1'b0;
		pend_ret_nxt = 1'b0;
		pend_two_nxt = 1'b0;
		pend_mss_nxt = pend_mss_r;
		ext_en_nxt = ext_set_enable; // [RULE_04]
		unique case (state_r)
			CSX_RUN:
			begin
				// second cycle of a two-cycle op; fetch holds off while busy
				if (pend_two_r)
				begin
					ret_nxt = pend_ret_r; // [RULE_11]
					op_nxt = csx_pkg::CSX_NOP;
					valid_nxt = 1'b1;
				end
				else if (instr_valid)
				begin
					if (instr_word[15:9] == csx_pkg::CSX_OP_CMPEQ) // [RULE_01]
					begin
						op_nxt = csx_pkg::CSX_CMP;
						valid_nxt = 1'b1;
						a_nxt = eff;
						idx_nxt = eff_idx;
						if (equal) // [RULE_02]
						begin
							fl_nxt = 1'b1;
							state_nxt = CSX_SKIP1;
						end
					end
					else if (instr_word == csx_pkg::CSX_OP_CALL_VIA_WORKING_REG && ext_en_r) // [RULE_08]
					begin
						op_nxt = csx_pkg::CSX_CALL_VIA_WORKING_REG;
						valid_nxt = 1'b1;
						call_nxt = 1'b1;
						pend_two_nxt = 1'b1; // [RULE_08]
					end
					else if (ext_en_r && instr_word[15:10] == csx_pkg::CSX_OP_EXT_HI) // [RULE_05]
					begin
						valid_nxt = 1'b1;
						ptr_nxt = instr_word[7:6];
						lit_nxt = instr_word[7:0];
						unique case (instr_word[9:8])
							csx_pkg::CSX_EXT_ADD, csx_pkg::CSX_EXT_SUB:
							begin
								lit_nxt = {2'h0, instr_word[5:0]};
								if (instr_word[7:6] == csx_pkg::CSX_PTR_RET) // [RULE_06] [RULE_07]
								begin
									ptr_nxt = csx_pkg::CSX_PTR_TWO;
									pend_ret_nxt = 1'b1; // [RULE_11]
									pend_two_nxt = 1'b1; // [RULE_06] [RULE_07]
									op_nxt = (instr_word[8]) ? csx_pkg::CSX_SUBRET
										: csx_pkg::CSX_ADDRET;
								end
								else
								begin
									op_nxt = (instr_word[8]) ? csx_pkg::CSX_SUBP
										: csx_pkg::CSX_ADDP;
								end
							end
							csx_pkg::CSX_EXT_PUSH: // [RULE_10]
							begin
								op_nxt = csx_pkg::CSX_PUSH;
								ptr_nxt = csx_pkg::CSX_PTR_TWO;
								a_nxt = pointer_two;
								b_nxt = pointer_two - {4'h0, csx_pkg::CSX_ONE};
							end
							csx_pkg::CSX_EXT_MOVE: // [RULE_09]
							begin
								ptr_nxt = csx_pkg::CSX_PTR_TWO;
								a_nxt = csx_idx(pointer_two, instr_word[6:0]);
								pend_mss_nxt = instr_word[7];
								op_nxt = (instr_word[7]) ? csx_pkg::CSX_MOVE_INDEXED_TO_INDEXED
									: csx_pkg::CSX_MOVE_INDEXED_TO_FILE;
								state_nxt = CSX_SECOND;
							end
						endcase
					end
				end
			end
			CSX_SKIP1:
			begin
				// discarded word executes as a no-operation
				op_nxt = csx_pkg::CSX_NOP;
				valid_nxt = 1'b1;
				if (instr_two_word) // [RULE_03]
				begin
					fl_nxt = 1'b1;
					state_nxt = CSX_SKIP2;
				end
				else
				begin
					state_nxt = CSX_RUN;
				end
			end
			CSX_SKIP2:
			begin
				op_nxt = csx_pkg::CSX_NOP; // [RULE_03]
				valid_nxt = 1'b1;
				state_nxt = CSX_RUN;
			end
			CSX_SECOND:
			begin
				// wait for the second word, then resolve destination
				if (instr_valid && instr_word[15:12] == csx_pkg::CSX_OP_SECOND) // [RULE_09]
				begin
					op_nxt = op_r;
					valid_nxt = 1'b1;
					b_nxt = pend_mss_r ? csx_idx(pointer_two, instr_word[6:0])
						: instr_word[11:0];
					state_nxt = CSX_RUN;
				end
				else
				begin
					op_nxt = op_r;
				end
			end
		endcase
	end

	// ==========================================
	// registers
	always_ff @(posedge clock or negedge rst_n)
	begin
		if (!rst_n)
		begin
			state_r <= CSX_RUN;
			op_r <= csx_pkg::CSX_NONE;
			valid_r <= 1'b0;
			ptr_r <= 2'h0;
			lit_r <= 8'h00;
			a_r <= 12'h000;
			b_r <= 12'h000;
			idx_r <= 1'b0;
			ret_r <= 1'b0;
			call_r <= 1'b0;
			fl_r <= 1'b0;
			pend_ret_r <= 1'b0;
			pend_two_r <= 1'b0;
			pend_mss_r <= 1'b0;
			ext_en_r <= 1'b0; // inactive by default
		end
		else
		begin
			state_r <= state_nxt;
			op_r <= op_nxt;
			valid_r <= valid_nxt;
			ptr_r <= ptr_nxt;
			lit_r <= lit_nxt;
			a_r <= a_nxt;
			b_r <= b_nxt;
			idx_r <= idx_nxt;
			ret_r <= ret_nxt;
			call_r <= call_nxt;
			fl_r <= fl_nxt;
			pend_ret_r <= pend_ret_nxt;
			pend_two_r <= pend_two_nxt;
			pend_mss_r <= pend_mss_nxt;
			ext_en_r <= ext_en_nxt;
		end
	end

	// outputs straight from flops
	assign op_code = op_r;
	assign op_valid = valid_r;
	assign ptr_sel = ptr_r;
	assign literal = lit_r;
	assign addr_a = a_r;
	assign addr_b = b_r;
	assign addr_indexed = idx_r;
	assign do_return = ret_r;
	assign do_call = call_r;
	assign skip_flush = fl_r;
	assign busy = pend_two_r;

	// ==========================================
	// checks
	property p_skip_nop;
		@(posedge clock) disable iff (!rst_n)
		(state_r == CSX_SKIP1) |=> (op_r == csx_pkg::CSX_NOP);
	endproperty
	a_skip_nop: assert property (p_skip_nop) else $error("skip not nop"); // [RULE_02]
	property p_ret_follows;
		@(posedge clock) disable iff (!rst_n)
		(op_r == csx_pkg::CSX_ADDRET || op_r == csx_pkg::CSX_SUBRET) && valid_r
		|=> do_return;
	endproperty
	a_ret_follows: assert property (p_ret_follows) else $error("no return"); // [RULE_11]
	property p_ext_off;
		@(posedge clock) disable iff (!rst_n)
		!ext_en_r |=> !(op_r inside {csx_pkg::CSX_PUSH, csx_pkg::CSX_CALL_VIA_WORKING_REG});
	endproperty
	a_ext_off: assert property (p_ext_off) else $error("ext while off"); // [RULE_04]
	// one no-operation cycle of a multi-cycle op
	sequence s_nop_cycle;
		(op_r == csx_pkg::CSX_NOP) && valid_r;
	endsequence
	// equal operands flag the flush on the compare's own result cycle
	property p_cmp_flush;
		@(posedge clock) disable iff (!rst_n)
		(state_r == CSX_RUN && !pend_two_r && instr_valid
			&& instr_word[15:9] == csx_pkg::CSX_OP_CMPEQ && file_data == working_register)
		|=> (skip_flush && op_r == csx_pkg::CSX_CMP);
	endproperty
	a_cmp_flush: assert property (p_cmp_flush) else $error("equal compare not flushed"); // [RULE_02]
	// a skipped two-word instruction costs two no-operation cycles
	property p_skip_two;
		@(posedge clock) disable iff (!rst_n)
		(state_r == CSX_SKIP1 && instr_two_word) |=> s_nop_cycle ##1 s_nop_cycle;
	endproperty
	a_skip_two: assert property (p_skip_two) else $error("two-word skip too short"); // [RULE_03]
	// call through the working register raises busy with do_call, then one no-operation cycle
	property p_call_two;
		@(posedge clock) disable iff (!rst_n)
		(op_r == csx_pkg::CSX_CALL_VIA_WORKING_REG && valid_r) |-> (do_call && busy) ##1 s_nop_cycle;
	endproperty
	a_call_two: assert property (p_call_two) else $error("call not two cycles"); // [RULE_08]
	// push addresses pointer two and its decremented value
	property p_push_dec;
		@(posedge clock) disable iff (!rst_n)
		(op_r == csx_pkg::CSX_PUSH && valid_r)
		|-> (ptr_sel == csx_pkg::CSX_PTR_TWO && addr_b == addr_a - {4'h0, csx_pkg::CSX_ONE});
	endproperty
	a_push_dec: assert property (p_push_dec) else $error("push address wrong"); // [RULE_10]
endmodule // csx_decoder
`default_nettype wire

// ### rtl/csx_pkg.sv
// Operation
// [RULE_01] compare file with working register, no flags
// [RULE_02] equal compare discards next word, two cycles
// [RULE_03] discarded two-word instruction costs third cycle
// [RULE_04] extension inactive unless enable bit set
// [RULE_05] eight extra pointer literal instructions when enabled
// [RULE_06] add literal to pointer; field three returns
// [RULE_07] subtract literal from pointer; field three returns
// [RULE_08] fixed word calls through working register
// [RULE_09] two-word indexed moves, bit seven selects form
// [RULE_10] push literal at pointer two, then decrement
// [RULE_11] pointer two add/subtract forms also return
// [RULE_12] access bit picks access bank or bank select
// [RULE_13] extension, access zero, low address indexes pointer two
`default_nettype none
package csx_pkg;
	// ==========================================
	// opcode patterns
	localparam logic [6:0] CSX_OP_CMPEQ = 7'h31; // 0110 001
	localparam logic [7:0] CSX_OP_EXT = 8'hE8; // 1110 10xx / 1110 1011
	localparam logic [5:0] CSX_OP_EXT_HI = 6'h3A; // 1110 10
	localparam logic [1:0] CSX_EXT_ADD = 2'h0;
	localparam logic [1:0] CSX_EXT_SUB = 2'h1;
	localparam logic [1:0] CSX_EXT_PUSH = 2'h2;
	localparam logic [1:0] CSX_EXT_MOVE = 2'h3;
	localparam logic [15:0] CSX_OP_CALL_VIA_WORKING_REG = 16'h0014;
	localparam logic [3:0] CSX_OP_SECOND = 4'hF; // second-word prefix
	localparam logic [1:0] CSX_PTR_TWO = 2'h2;
	localparam logic [1:0] CSX_PTR_RET = 2'h3;
	localparam logic [7:0] CSX_IDX_LIMIT = 8'h5F; // 95
	localparam logic [3:0] CSX_ACCESS_HI = 4'hF; // access bank upper part, from 0x60 up
	localparam logic [7:0] CSX_ACCESS_SPLIT = 8'h60;
	localparam logic [7:0] CSX_ONE = 8'h01;
	// ==========================================
	// operation codes presented to the datapath
	typedef enum logic [3:0] {
		CSX_NONE, CSX_CMP, CSX_ADDP, CSX_SUBP, CSX_ADDRET, CSX_SUBRET,
		CSX_CALL_VIA_WORKING_REG, CSX_PUSH, CSX_MOVE_INDEXED_TO_FILE, CSX_MOVE_INDEXED_TO_INDEXED, CSX_NOP
	} csx_op_type;
endpackage
`default_nettype wire

// ### tb/csx_decoder_bench.sv
`timescale 1ns/1ps
`default_nettype none
module csx_decoder_bench;
	// ==========================================
	// decoder hookup
	logic clock, rst_n, ext_set_enable, instr_valid, instr_two_word;
	logic [15:0] instr_word;
	logic [7:0] file_data, working_register, literal;
	logic [3:0] bank_select_register, op_code;
	logic [11:0] pointer_two, addr_a, addr_b;
	logic [1:0] ptr_sel;
	logic op_valid, addr_indexed, do_return, do_call, skip_flush, busy;
	// tallies of one watch window
	logic [15:0] g_op, g_lit, g_a, g_b, g_ps, g_ix;
	int error_cnt, samples_checked, nv, nn, nr, nc, nf, nb, ne, e;
	logic [31:0] seed;
	csx_decoder u_csx_decoder (.clock, .rst_n, .ext_set_enable, .instr_valid, .instr_word,
		.instr_two_word, .file_data, .working_register, .bank_select_register, .pointer_two,
		.op_code, .op_valid, .ptr_sel, .literal, .addr_a, .addr_b, .addr_indexed, .do_return,
		.do_call, .skip_flush, .busy);
	csx_fetch_model u_csx_fetch_model (.clock, .instr_valid, .instr_word, .instr_two_word,
		.file_data, .working_register);
	// ==========================================
	// clock, 8 ns
	initial
	begin
		clock = 1'b0;
		forever #4 clock = ~clock;
	end
	// hang guard, well past the longest run
	initial
	begin
		#200000;
		error_cnt++;
		print_verdict();
	end
	// ==========================================
	// helpers
	function automatic logic [31:0] xs(input logic [31:0] s);
		logic [31:0] x;
		x = s ^ (s << 13);
		x = x ^ (x >> 17);
		return x ^ (x << 5);
	endfunction
	// reference decode, codes in enum order
	function automatic int exp_op(input logic [15:0] w, input logic x);
		if (w[15:9] == 7'h31)
			return 1;
		if (!x)
			return 0;
		if (w == 16'h0014)
			return 6;
		if (w[15:10] != 6'h3A)
			return 0;
		if (w[9:8] == 2'h3)
			return w[7] ? 9 : 8;
		if (w[9:8] == 2'h2)
			return 7;
		return 2 + int'(w[8]) + (w[7:6] == 2'h3 ? 2 : 0);
	endfunction
	task automatic chk(input logic [15:0] got, input logic [15:0] exp);
		samples_checked++;
		if (got !== exp)
		begin
			error_cnt++;
			$display("[FAIL] %0t got %0h exp %0h", $time, got, exp);
		end
	endtask
	// six cycles of output after a word
	task automatic watch();
		nv = 0;
		nn = 0;
		nr = 0;
		nc = 0;
		nf = 0;
		nb = 0;
		g_op = 16'h0000;
		repeat (6)
		begin
			@(negedge clock);
			if (op_valid === 1'b1 && nv == 0)
			begin
				g_op = 16'(op_code);
				g_lit = 16'(literal);
				g_a = 16'(addr_a);
				g_b = 16'(addr_b);
				g_ps = 16'(ptr_sel);
				g_ix = 16'(addr_indexed);
			end
			nv += int'(op_valid === 1'b1);
			nn += int'(op_code === 4'hA);
			nr += int'(do_return === 1'b1);
			nc += int'(do_call === 1'b1);
			nf += int'(skip_flush === 1'b1);
			nb += int'(busy === 1'b1);
		end
	endtask
	task automatic print_verdict();
		if (error_cnt == 0 && samples_checked > 0)
			$display("verification passed");
		else
			$display("verification failed");
		$finish;
	endtask
	// ==========================================
	// random instruction mix against the reference
	initial
	begin
		logic [15:0] w, w2;
		logic [7:0] fd, wr, k;
		logic two, hit;
		rst_n = 1'b0;
		ext_set_enable = 1'b0;
		bank_select_register = 4'h0;
		pointer_two = 12'h000;
		seed = 32'h3077; // 12407
		error_cnt = 0;
		samples_checked = 0;
		repeat (3) @(posedge clock);
		#1;
		rst_n = 1'b1;
		for (int i = 0; i < 600; i++)
		begin
			// bench inputs move just after a rising edge, as the fetch side does
			@(posedge clock);
			#1;
			seed = xs(seed);
			if (i % 12 == 0)
				ext_set_enable = seed[31];
			bank_select_register = seed[27:24];
			pointer_two = seed[23:12];
			k = seed[11:4];
			fd = seed[19:12];
			wr = seed[5] ? fd : seed[27:20];
			two = seed[6];
			w2 = {4'hF, seed[27:16]};
			case (seed[2:0])
				3'h0, 3'h1: w = {7'h31, seed[3], k};
				3'h2: w = {7'h74, seed[3], k};
				3'h3: w = {8'hEA, k};
				3'h4: w = 16'h0014;
				3'h5: w = {8'hEB, k};
				default: w = {4'h2, seed[11:0]};
			endcase
			e = exp_op(w, ext_set_enable);
			hit = (e == 1) && (fd == wr);
			// skipped words and second cycles both show as no-operations
			ne = hit ? (two ? 2 : 1) : int'(e >= 4 && e <= 6);
			u_csx_fetch_model.send(w, fd, wr, two);
			if (w[15:8] == 8'hEB)
				u_csx_fetch_model.send(w2, fd, wr, two);
			watch();
			chk(g_op, 16'(e));
			chk(16'(nr), 16'(e == 4 || e == 5));
			chk(16'(nc), 16'(e == 6));
			chk(16'(nb), 16'(e >= 4 && e <= 6));
			chk(16'(nf), 16'(hit ? ne : 0));
			chk(16'(nn), 16'(ne));
			chk(16'(nv), 16'(int'(e != 0) + ne));
			if (e >= 2 && e <= 5)
			begin
				chk(g_lit, {10'h000, w[5:0]});
				chk(g_ps, e > 3 ? 16'h0002 : 16'(w[7:6]));
			end
			if (e == 7)
			begin
				chk(g_lit, 16'(k));
				chk(g_ps, 16'h0002);
				chk(g_a, 16'(pointer_two));
				chk(g_b, {4'h0, pointer_two - 12'h001});
			end
			if (e >= 8)
			begin
				chk(g_a, {4'h0, pointer_two + {5'h00, w[6:0]}});
				chk(g_b, e == 9 ? {4'h0, pointer_two + {5'h00, w2[6:0]}} : {4'h0, w2[11:0]});
			end
			if (e == 1)
			begin
				hit = !w[8] && ext_set_enable && w[7:0] <= 8'h5F;
				chk(g_ix, 16'(hit));
				if (w[8])
					chk(g_a, {4'h0, bank_select_register, w[7:0]});
				else if (hit)
					chk(g_a, {4'h0, pointer_two + {4'h0, w[7:0]}});
				else
					chk(g_a, {4'h0, w[7:0] < 8'h60 ? 4'h0 : 4'hF, w[7:0]});
			end
		end
		print_verdict();
	end
endmodule // csx_decoder_bench
`default_nettype wire

// ### tb/csx_fetch_model.sv
`timescale 1ns/1ps
`default_nettype none
// ==========================================
// fetch side stand-in: hands over one word per call
module csx_fetch_model
(
	// clock
	input wire logic clock,
	// word and operands
	output logic instr_valid,
	output logic [15:0] instr_word,
	output logic instr_two_word,
	output logic [7:0] file_data,
	output logic [7:0] working_register
);
	// quiet fetch side until the first word
	initial
	begin
		instr_valid = 1'b0;
		instr_word = 16'h0000;
		instr_two_word = 1'b0;
		file_data = 8'h00;
		working_register = 8'h00;
	end
	// word held for exactly one taking edge, then scrambled
	task automatic send(input logic [15:0] w, input logic [7:0] f, input logic [7:0] wr,
		input logic two);
		@(posedge clock);
		#1;
		instr_valid = 1'b1;
		instr_word = w;
		file_data = f;
		working_register = wr;
		instr_two_word = two;
		@(posedge clock);
		#1;
		instr_valid = 1'b0;
		instr_word = ~w; // stale word must not look valid
		file_data = ~f;
	endtask
endmodule // csx_fetch_model
`default_nettype wire
